// ==== rtl/tsb_top.sv ====
/*
  Two-wire serial slave front end of a temperature sensor with a continuous
  conversion loop. Assumes the bus pins arrive asynchronously and that the
  sensor core presents a signed 12-bit sample on the core clock.
*/
`timescale 1ns/100ps
`include "tsb_consts.svh"
`default_nettype none
module tsb_top #(
  parameter logic [3:0]  TYPE_CODE     = 4'h5,      // Arbitrary value
  parameter bit          USE_STRAP     = 1'b1,
  parameter logic [2:0]  FIXED_SEL     = 3'h0,
  parameter int unsigned CONV_BASE_CYC = 20000
) (
  input  wire logic               core_clk,
  input  wire logic               sys_rst,
  input  wire logic               scl_in,
  input  wire logic               sda_in,
  output logic                    sda_out,
  output logic                    sda_oe,
  input  wire logic               addr_sel_bit2,
  input  wire logic               addr_sel_bit1,
  input  wire logic               addr_sel_bit0,
  input  wire tsb_pkg::tsb_temp12_t temp_sample,
  output logic                    hs_mode,
  output logic [1:0]              resolution,
  output logic [15:0]             temp_result
);
  import tsb_pkg::*;

  localparam logic [3:0] FILT_STD = 4'((`TSB_FILT_STD_NS) / (`TSB_CLK_NS));
  localparam logic [3:0] FILT_HS  = 4'((`TSB_FILT_HS_NS) / (`TSB_CLK_NS));

  tsb_state_t q, d;
  logic       scl_rise, scl_fall, start_c, stop_c;
  logic [3:0] flim;
  logic [2:0] asel;
  logic [7:0] tx_byte;
  logic [11:0] res_mask;
  logic [31:0] conv_lim;

  // Strap source, filter length, outgoing byte, conversion length
  assign asel     = USE_STRAP ? q.asel_s : FIXED_SEL;
  assign flim     = q.hs ? FILT_HS : FILT_STD;
  assign res_mask = 12'hFFF << (`TSB_RES_MAX - q.res);
  assign conv_lim = CONV_BASE_CYC << q.res;
  assign tx_byte  = (q.ptr == `TSB_PTR_CFG) ? {1'b0, q.res, 5'h00} :
                    (q.byte_idx ? q.temp[7:0] : q.temp[15:8]);

  // Edge and condition detection on filtered lines
  assign scl_rise = ~q.scl_f & d.scl_f;
  assign scl_fall = q.scl_f & ~d.scl_f;
  assign start_c  = q.scl_f & d.scl_f & q.sda_f & ~d.sda_f;
  assign stop_c   = q.scl_f & d.scl_f & ~q.sda_f & d.sda_f;

  // Next-state logic for the whole block
  always_comb begin
    d = q;
    d.scl_m  = scl_in;
    d.scl_s  = q.scl_m;
    d.sda_m  = sda_in;
    d.sda_s  = q.sda_m;
    d.asel_m = {addr_sel_bit2, addr_sel_bit1, addr_sel_bit0};
    d.asel_s = q.asel_m;
    d.sda_o  = 1'b0;
    // Spike filters: accept a level once stable for flim cycles
    if (q.scl_s != q.scl_f) begin
      d.scl_cnt = q.scl_cnt + 4'h1;
      if (q.scl_cnt + 4'h1 >= flim) begin
        d.scl_f   = q.scl_s;
        d.scl_cnt = 4'h0;
      end
    end else begin
      d.scl_cnt = 4'h0;
    end
    if (q.sda_s != q.sda_f) begin
      d.sda_cnt = q.sda_cnt + 4'h1;
      if (q.sda_cnt + 4'h1 >= flim) begin
        d.sda_f   = q.sda_s;
        d.sda_cnt = 4'h0;
      end
    end else begin
      d.sda_cnt = 4'h0;
    end
    // Continuous conversion loop with masked result
    d.conv_done = 1'b0;
    if (q.conv_cnt + 32'h1 >= conv_lim) begin
      d.conv_cnt  = 32'h0;
      d.conv_done = 1'b1;
      d.temp      = {temp_sample & res_mask, `TSB_TEMP_LSB_PAD};
    end else begin
      d.conv_cnt  = q.conv_cnt + 32'h1;
    end
    // Bus protocol
    if (stop_c) begin
      d.st     = ST_IDLE;
      d.sda_oe = 1'b0;
      d.hs     = 1'b0;
    end else if (start_c) begin
      d.st         = ST_RX;
      d.addr_phase = 1'b1;
      d.bit_cnt    = 4'h0;
      d.sda_oe     = 1'b0;
    end else begin
      unique case (q.st)
        ST_IDLE: begin
          d.sda_oe = 1'b0;
        end
        ST_RX: begin
          if (scl_rise && q.bit_cnt < `TSB_BITS_PER_BYTE) begin
            d.shreg   = {q.shreg[6:0], q.sda_f};
            d.bit_cnt = q.bit_cnt + 4'h1;
          end else if (scl_fall && q.bit_cnt == `TSB_BITS_PER_BYTE) begin
            d.bit_cnt = 4'h0;
            if (q.addr_phase) begin
              d.addr_phase = 1'b0;
              if (q.shreg[7:3] == `TSB_HS_CODE) begin
                d.hs = 1'b1;
                d.st = ST_IDLE;
              end else if (q.shreg[7:1] == {TYPE_CODE, asel}) begin
                d.rw       = q.shreg[0];
                d.first    = 1'b1;
                d.byte_idx = 1'b0;
                d.st       = ST_ACK;
                d.sda_oe   = 1'b1;
              end else begin
                d.st = ST_IDLE;
              end
            end else if (q.first) begin
              d.ptr    = q.shreg;
              d.first  = 1'b0;
              d.st     = ST_ACK;
              d.sda_oe = 1'b1;
            end else if (q.ptr == `TSB_PTR_CFG) begin
              d.res    = q.shreg[`TSB_CFG_RES_LSB +: 2];
              d.st     = ST_ACK;
              d.sda_oe = 1'b1;
            end
            // Other writes get no ack and stay receiving
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            if (q.rw) begin
              d.st       = ST_TX;
              d.sda_oe   = ~tx_byte[7];
              d.shreg    = {tx_byte[6:0], 1'b0};
              d.bit_cnt  = 4'h1;
              d.byte_idx = ~q.byte_idx;
            end else begin
              d.st      = ST_RX;
              d.sda_oe  = 1'b0;
              d.bit_cnt = 4'h0;
            end
          end
        end
        ST_TX: begin
          if (scl_fall) begin
            if (q.bit_cnt == `TSB_BITS_PER_BYTE) begin
              d.sda_oe  = 1'b0;
              d.st      = ST_MACK;
              d.bit_cnt = 4'h0;
            end else begin
              d.sda_oe  = ~q.shreg[7];
              d.shreg   = {q.shreg[6:0], 1'b0};
              d.bit_cnt = q.bit_cnt + 4'h1;
            end
          end
        end
        ST_MACK: begin
          if (scl_rise) begin
            if (q.sda_f) begin
              d.st = ST_IDLE;
            end else begin
              d.bit_cnt = 4'h1;
            end
          end else if (scl_fall && q.bit_cnt == 4'h1) begin
            d.st       = ST_TX;
            d.sda_oe   = ~tx_byte[7];
            d.shreg    = {tx_byte[6:0], 1'b0};
            d.bit_cnt  = 4'h1;
            d.byte_idx = ~q.byte_idx;
          end
        end
        default: begin
          d.st     = ST_IDLE;
          d.sda_oe = 1'b0;
        end
      endcase
    end
  end

  // State register with synchronous reset
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      q       <= '0;
      q.st    <= ST_IDLE;
      q.scl_f <= 1'b1;
      q.sda_f <= 1'b1;
      q.scl_m <= 1'b1;
      q.scl_s <= 1'b1;
      q.sda_m <= 1'b1;
      q.sda_s <= 1'b1;
      q.res   <= `TSB_RES_RESET;
    end else begin
      q <= d;
    end
  end

  // Outputs straight from the state register
  assign sda_out     = q.sda_o;
  assign sda_oe      = q.sda_oe;
  assign hs_mode     = q.hs;
  assign resolution  = q.res;
  assign temp_result = q.temp;

  // Checks
  property p_addr_ack;
    @(posedge core_clk) disable iff (sys_rst)
      (q.st == ST_RX && d.st == ST_ACK && q.addr_phase) |-> q.shreg[7:1] == {TYPE_CODE, asel};
  endproperty
  a_addr_ack: assert property (p_addr_ack) else $error("Ack on wrong address");

  property p_hs_enter;
    @(posedge core_clk) disable iff (sys_rst)
      (q.st == ST_RX && q.addr_phase && scl_fall && q.bit_cnt == 4'h8 && q.shreg[7:3] == 5'h01 && !stop_c)
      |=> hs_mode && q.st == ST_IDLE && !sda_oe;
  endproperty
  a_hs_enter: assert property (p_hs_enter) else $error("Fast code not handled");

  property p_hs_noack;
    @(posedge core_clk) disable iff (sys_rst)
      $rose(q.hs) |-> !sda_oe [*8];
  endproperty
  a_hs_noack: assert property (p_hs_noack) else $error("Fast code acknowledged");

  property p_stop_rev;
    @(posedge core_clk) disable iff (sys_rst)
      stop_c |=> !hs_mode && !sda_oe;
  endproperty
  a_stop_rev: assert property (p_stop_rev) else $error("Stop did not revert");

  property p_low_zero;
    @(posedge core_clk) disable iff (sys_rst)
      ((temp_result[15:4] & ~(12'hFFF << (`TSB_RES_MAX - resolution))) == 12'h000) || $changed(resolution);
  endproperty
  a_low_zero: assert property (p_low_zero) else $error("Low result bits set");

  property p_conv_upd;
    @(posedge core_clk) disable iff (sys_rst)
      q.conv_done |-> temp_result[15:4] == ($past(temp_sample) & (12'hFFF << (`TSB_RES_MAX - $past(resolution))));
  endproperty
  a_conv_upd: assert property (p_conv_upd) else $error("Result not updated");

  property p_res_reset;
    @(posedge core_clk) $fell(sys_rst) |-> resolution == `TSB_RES_RESET;
  endproperty
  a_res_reset: assert property (p_res_reset) else $error("Resolution not nine bits");

  property p_ack_hold;
    @(posedge core_clk) disable iff (sys_rst)
      (q.st == ST_ACK && !scl_fall && !start_c && !stop_c) |=> sda_oe;
  endproperty
  a_ack_hold: assert property (p_ack_hold) else $error("Ack released early");

  property p_ro_nack;
    @(posedge core_clk) disable iff (sys_rst)
      (q.st == ST_RX && !q.addr_phase && !q.first && !q.rw && q.ptr == 8'h00 && scl_fall && q.bit_cnt == 4'h8)
      |=> q.st != ST_ACK && !sda_oe;
  endproperty
  a_ro_nack: assert property (p_ro_nack) else $error("Read-only write acked");

  c_read:  cover property (@(posedge core_clk) q.st == ST_MACK ##1 q.st == ST_TX);
  c_hs:    cover property (@(posedge core_clk) $rose(q.hs));
  c_cfg:   cover property (@(posedge core_clk) $changed(q.res));
  c_nomat: cover property (@(posedge core_clk) q.addr_phase && q.st == ST_RX ##1 q.st == ST_IDLE);

endmodule : tsb_top
`default_nettype wire

// ==== include/tsb_consts.svh ====
/*
  Constants of the two-wire temperature sensor slave: codes, field positions,
  reset values and filter timing. Assumes a 250 MHz core clock.
*/
`ifndef TSB_CONSTS_SVH
`define TSB_CONSTS_SVH

`define TSB_CLK_NS         4
`define TSB_FILT_STD_NS    20
`define TSB_FILT_HS_NS     8
`define TSB_HS_CODE        5'h01
`define TSB_PTR_TEMP       8'h00
`define TSB_PTR_CFG        8'h01
`define TSB_CFG_RES_LSB    5
`define TSB_RES_RESET      2'h0
`define TSB_RES_MAX        2'h3
`define TSB_BITS_PER_BYTE  4'h8
`define TSB_TEMP_LSB_PAD   4'h0

`endif

// ==== include/tsb_pkg.sv ====
/*
  Types of the two-wire temperature sensor slave.
  Sets its own state encodings and uses nothing from tsb_consts.svh.
*/
`default_nettype none
package tsb_pkg;

  typedef logic signed [11:0] tsb_temp12_t;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_RX   = 5'h02,
    ST_ACK  = 5'h04,
    ST_TX   = 5'h08,
    ST_MACK = 5'h10
  } tsb_st_t;

  typedef struct packed {
    logic        scl_m, scl_s, sda_m, sda_s;
    logic [2:0]  asel_m, asel_s;
    logic        scl_f, sda_f;
    logic [3:0]  scl_cnt, sda_cnt;
    tsb_st_t     st;
    logic        addr_phase;
    logic [3:0]  bit_cnt;
    logic [7:0]  shreg;
    logic        rw;
    logic [7:0]  ptr;
    logic        first;
    logic        byte_idx;
    logic        hs;
    logic        sda_oe;
    logic        sda_o;
    logic [1:0]  res;
    logic [15:0] temp;
    logic [31:0] conv_cnt;
    logic        conv_done;
  } tsb_state_t;

endpackage : tsb_pkg
`default_nettype wire

// ==== test/tsb_bus_master.sv ====
/*
  Two-wire bus master model with an 80 ns SCL, still between frames.
  Assumes a pull-up on SDA and the core clock as its time base.
*/
`timescale 1ns/100ps
`default_nettype none
module tsb_bus_master (
  input  wire logic       core_clk,
  input  wire logic       sda_in,
  output logic            scl,
  output logic            sda,
  output logic            obs_valid,
  output logic [7:0]      obs_byte
);
  // Idle bus, both lines released
  initial begin
    scl = 1'b1;
    sda = 1'b1;
    obs_valid = 1'b0;
    obs_byte = 8'h00;
  end
  // Hold one bus state for n cycles
  task automatic seg(input logic c, input logic d, input int n);
    scl <= c;
    sda <= d;
    repeat (n) @(posedge core_clk);
  endtask : seg
  // SDA moves only while SCL low; read at end of high
  task automatic bit_io(input logic b, output logic r);
    seg(1'b0, sda, 5);
    seg(1'b0, b, 5);
    seg(1'b1, b, 10);
    r = sda_in;
  endtask : bit_io
  // Start, or repeated start after lowering SCL
  task automatic start();
    if (!(scl && sda_in)) begin
      seg(1'b0, sda, 5);
      seg(1'b0, 1'b1, 5);
      seg(1'b1, 1'b1, 10);
    end
    seg(1'b1, 1'b0, 10);
  endtask : start
  // Stop: SDA rises while SCL high
  task automatic stop();
    seg(1'b0, sda, 5);
    seg(1'b0, 1'b0, 5);
    seg(1'b1, 1'b0, 10);
    seg(1'b1, 1'b1, 10);
  endtask : stop
  // One-cycle report of a byte or an ack bit
  task automatic report(input logic [7:0] v);
    obs_byte  <= v;
    obs_valid <= 1'b1;
    @(posedge core_clk);
    obs_valid <= 1'b0;
  endtask : report
  // MSB first, SDA released in the ninth clock
  task automatic put_byte(input logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
    end
    bit_io(1'b1, r);
    report({7'h0, r});
  endtask : put_byte
  // Byte in, then master ack or nack
  task automatic get_byte(input logic mack);
    logic [7:0] d;
    logic       r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, d[i]);
    end
    bit_io(mack, r);
    report(d);
  endtask : get_byte
endmodule : tsb_bus_master
`default_nettype wire

// ==== test/tsb_top_tb_top.sv ====
/*
  Self-checking bench of the two-wire sensor slave.
  Assumes tsb_pkg and the bus master model tsb_bus_master.
*/
`timescale 1ns/100ps
`default_nettype none
module tsb_top_tb_top;
  import tsb_pkg::*;
  localparam int         BASE = 50;
  localparam logic [3:0] TYPE = 4'hA;  // Arbitrary value
  localparam logic [2:0] FIX  = 3'h0;
  logic        core_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        sweep = 1'b0;
  logic        smp_v = 1'b0;
  logic [15:0] smp_val = 16'h0;
  logic [2:0]  strap;
  tsb_temp12_t sample;
  logic        m_scl, m_sda, sda_out, sda_oe, hs, obs_v, sda_line;
  logic        fx_out, fx_oe;
  logic        fx_seen = 1'b0;
  logic [1:0]  res;
  logic [7:0]  obs_b;
  logic [15:0] tres;
  logic [15:0] exp_q[$];
  logic [6:0]  addr;
  int          num_errors = 0;
  int          n_compared = 0;
  // Open-drain wire with pull-up; clock
  assign sda_line = m_sda & ~(sda_oe & ~sda_out) & ~(fx_oe & ~fx_out);
  assign addr = {TYPE, strap};
  always #2 core_clk = ~core_clk;
  tsb_top #(.TYPE_CODE(TYPE), .USE_STRAP(1'b1), .FIXED_SEL(3'h0), .CONV_BASE_CYC(BASE)) u_tsb_top (
    .core_clk(core_clk), .sys_rst(sys_rst), .scl_in(m_scl), .sda_in(sda_line), .sda_out(sda_out),
    .sda_oe(sda_oe), .addr_sel_bit2(strap[2]), .addr_sel_bit1(strap[1]), .addr_sel_bit0(strap[0]),
    .temp_sample(sample), .hs_mode(hs), .resolution(res), .temp_result(tres));
  tsb_bus_master u_tsb_bus_master (.core_clk(core_clk), .sda_in(sda_line), .scl(m_scl), .sda(m_sda),
    .obs_valid(obs_v), .obs_byte(obs_b));
  // Second slave on the fixed internal setting, strap pins ignored
  tsb_top #(.TYPE_CODE(TYPE), .USE_STRAP(1'b0), .FIXED_SEL(FIX), .CONV_BASE_CYC(BASE)) u_tsb_top_fix (
    .core_clk(core_clk), .sys_rst(sys_rst), .scl_in(m_scl), .sda_in(sda_line), .sda_out(fx_out),
    .sda_oe(fx_oe), .addr_sel_bit2(strap[2]), .addr_sel_bit1(strap[1]), .addr_sel_bit0(strap[0]),
    .temp_sample(sample), .hs_mode(), .resolution(), .temp_result());
  // Notes any drive from the second slave
  always @(posedge core_clk) begin
    if (fx_oe) begin
      fx_seen <= 1'b1;
    end
  end
  // Compare and count
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  // Verdict, end of run
  task automatic final_report();
    if (num_errors == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : final_report
  // Transfers and port samples, expectation noted first
  task automatic wr(input logic [7:0] d, input logic a);
    exp_q.push_back({15'h0, a});
    u_tsb_bus_master.put_byte(d);
  endtask : wr
  task automatic rd(input logic mack, input logic [7:0] e);
    exp_q.push_back({8'h0, e});
    u_tsb_bus_master.get_byte(mack);
  endtask : rd
  task automatic port(input logic [15:0] seen, input logic [15:0] e);
    exp_q.push_back(e);
    smp_val <= seen;
    smp_v <= 1'b1;
    @(posedge core_clk);
    smp_v <= 1'b0;
    @(posedge core_clk);
  endtask : port
  task automatic st();
    u_tsb_bus_master.start();
  endtask : st
  task automatic sp();
    u_tsb_bus_master.stop();
  endtask : sp
  // Cycles until the result changes
  task automatic wait_chg(output int c);
    logic [15:0] t;
    t = tres;
    c = 0;
    while (tres === t && c < 2000) begin
      @(posedge core_clk);
      c++;
    end
  endtask : wait_chg
  // Expected result: masked sample over four zero bits
  function automatic logic [15:0] tfmt(input tsb_temp12_t s, input logic [1:0] r);
    return {s & (12'hFFF << (3 - r)), 4'h0};
  endfunction : tfmt
  // Sample sweep, every update differs
  always @(posedge core_clk) begin
    if (sweep) begin
      sample <= sample + 12'h080;
    end
  end
  // Oldest note against each result
  always @(posedge core_clk) begin
    if (obs_v || smp_v) begin
      check(obs_v ? {8'h0, obs_b} : smp_val, exp_q.size() > 0 ? exp_q.pop_front() : 16'hDEAD);
    end
  end
  // Watchdog
  initial begin
    repeat (60000) @(posedge core_clk);
    num_errors++;
    final_report();
  end
  // Main sequence
  initial begin
    logic [15:0] e;
    int          c;
    void'($urandom(8));
    strap = 3'($urandom);
    if ($countones(strap) < 2) begin
      strap = strap | 3'h6;  // Keep the fixed setting two bits away
    end
    sample = 12'h000;
    repeat (2) @(posedge core_clk);
    sys_rst <= 1'b0;
    repeat (20) @(posedge core_clk);
    port({13'h0, hs, res}, 16'h0);
    port(tres, 16'h0);
    // Each flipped address bit is refused
    for (int i = 0; i < 7; i++) begin
      st();
      wr({addr ^ (7'h01 << i), 1'b0}, 1'b1);
      sp();
    end
    // Every resolution: set, read back, update rate, result
    for (int r = 0; r < 4; r++) begin
      st();
      wr({addr, 1'b0}, 1'b0);
      wr(8'h01, 1'b0);
      wr({1'b0, 2'(r), 5'h00}, 1'b0);
      sp();
      port({14'h0, res}, 16'(r));
      st();
      wr({addr, 1'b1}, 1'b0);
      rd(1'b1, {1'b0, 2'(r), 5'h00});
      sp();
      sweep <= 1'b1;
      wait_chg(c);
      wait_chg(c);
      port(16'(c), 16'(BASE << r));
      sweep <= 1'b0;
      @(posedge core_clk);
      sample <= (r < 2) ? tsb_temp12_t'($urandom) : (r == 2 ? 12'h7FF : 12'h800);
      @(posedge core_clk);
      e = tfmt(sample, 2'(r));
      repeat (2 * (BASE << r) + 4) @(posedge core_clk);
      port(tres, e);
      st();
      wr({addr, 1'b0}, 1'b0);
      wr(8'h00, 1'b0);
      st();
      wr({addr, 1'b1}, 1'b0);
      rd(1'b0, e[15:8]);
      rd(1'b1, e[7:0]);
      sp();
    end
    // Data to the read-only result is refused
    st();
    wr({addr, 1'b0}, 1'b0);
    wr(8'h00, 1'b0);
    wr(8'h5A, 1'b1);
    sp();
    // Pinless slave stayed silent so far and answers only its fixed setting
    port({15'h0, fx_seen}, 16'h0);
    st();
    wr({TYPE, FIX, 1'b0}, 1'b0);
    sp();
    // Fast mode: code unanswered, kept over repeated start, left on stop
    st();
    wr({5'h01, strap}, 1'b1);
    port({15'h0, hs}, 16'h1);
    st();
    wr({addr, 1'b1}, 1'b0);
    rd(1'b1, e[15:8]);
    port({15'h0, hs}, 16'h1);
    sp();
    port({15'h0, hs}, 16'h0);
    final_report();
  end
endmodule : tsb_top_tb_top
`default_nettype wire
